// >>> dbsdc_pkg.sv
// constants, register map and state types of the bank select and dc brake block
package dbsdc_pkg;
    // ------------------------------------------------------------
    // clock and time units
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TIME_UNIT_MS = 100;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TIME_UNIT_MS;
    localparam int unsigned TICK_W = 25;
    localparam int unsigned PULSE_UNIT_HZ = 1000;
    localparam logic [17:0] PULSE_WRAP = 18'(CLK_HZ / (2 * PULSE_UNIT_HZ));
    localparam int unsigned NUM_INPUTS = 8;

    // ------------------------------------------------------------
    // input function codes and field encodings
    // ------------------------------------------------------------
    localparam logic [7:0] FN_DC_BRAKE = 8'h07;
    localparam logic [7:0] FN_BANK2 = 8'h08;
    localparam logic [7:0] FN_BANK3 = 8'h11;
    localparam logic [7:0] FN_OVL_SWAP = 8'h27;
    localparam logic [7:0] AUTO_ON = 8'h01;
    localparam logic [7:0] END_TIMED = 8'h00;
    localparam logic [7:0] END_INPUT = 8'h01;
    localparam logic [7:0] SRC_PARAM = 8'h02;
    localparam logic [1:0] OVL_ACC_STEADY = 2'h1;
    localparam logic [1:0] OVL_STEADY = 2'h2;
    localparam logic [1:0] OVL_ALWAYS = 2'h3;
    localparam logic [1:0] BANK_DEF = 2'h0;
    localparam logic [1:0] BANK_2 = 2'h1;
    localparam logic [1:0] BANK_3 = 2'h2;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_AUTO_EN = 8'h00;
    localparam logic [7:0] OFS_TRIG_FREQ = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_TORQUE = 8'h0C;
    localparam logic [7:0] OFS_DURATION = 8'h10;
    localparam logic [7:0] OFS_END_MODE = 8'h14;
    localparam logic [7:0] OFS_ST_TORQUE = 8'h18;
    localparam logic [7:0] OFS_ST_TIME = 8'h1C;
    localparam logic [7:0] OFS_PULSE_RATE = 8'h20;
    localparam logic [7:0] OFS_FSEL_LO = 8'h24;
    localparam logic [7:0] OFS_FSEL_HI = 8'h28;
    localparam logic [7:0] OFS_SRC_SEL = 8'h2C;
    localparam logic [7:0] OFS_SETPT0 = 8'h30;
    localparam logic [7:0] OFS_SETPT1 = 8'h34;
    localparam logic [7:0] OFS_SETPT2 = 8'h38;
    localparam logic [7:0] OFS_OVL0 = 8'h3C;
    localparam logic [7:0] OFS_OVL1 = 8'h40;
    localparam logic [7:0] OFS_FMAX0 = 8'h44;
    localparam logic [7:0] OFS_FMAX1 = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h4C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_AUTO_EN = 8'h00;
    localparam logic [15:0] RST_TRIG_FREQ = 16'h0032;
    localparam logic [7:0] RST_END_MODE = 8'h01;
    localparam logic [7:0] RST_PULSE_RATE = 8'h05;
    localparam logic [7:0] RST_SRC_SEL = 8'h01;
    localparam logic [1:0] RST_OVL_MODE = 2'h1;
    localparam logic [15:0] RST_OVL_LIM = 16'h0096;
    localparam logic [15:0] RST_FMAX = 16'h1388;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DELAY = 4'h2,
        ST_BRAKE = 4'h4,
        ST_START = 4'h8
    } dbsdc_fsm_t;

    typedef struct packed {
        logic [7:0] auto_en;
        logic [15:0] trig_freq;
        logic [15:0] delay_t;
        logic [7:0] torque;
        logic [15:0] dur_t;
        logic [7:0] end_mode;
        logic [7:0] st_torque;
        logic [15:0] st_time;
        logic [7:0] pulse_rate;
        logic [7:0][7:0] fsel;
        logic [7:0] src_sel;
        logic [2:0][15:0] setpt;
        logic [1:0][1:0] ovl_mode;
        logic [1:0][15:0] ovl_lim;
        logic [1:0][15:0] fmax;
        dbsdc_fsm_t state;
        logic [TICK_W-1:0] tick_cnt;
        logic [15:0] timer;
        logic by_input;
        logic [15:0] freq_prev;
        logic run_prev;
        logic [1:0] bank;
        logic [7:0] rate_lat;
        logic [16:0] pulse_acc;
        logic pulse;
        logic waitreq;
        logic [31:0] rdata;
        logic [15:0] setpt_o;
        logic [15:0] fmax_o;
        logic brake_o;
        logic [7:0] torque_o;
        logic hold_o;
        logic ovl_grp;
        logic reduce_o;
    } dbsdc_regs_t;
endpackage

// >>> dbsdc_top.sv
// bank select, dc brake sequencer and overload limit swap of the drive
// ------------------------------------------------------------
// How it works
// (RL1) input code 08 selects second bank
// (RL2) input code 17 selects third bank
// (RL3) controller selects banks only at standstill
// (RL4) released while turning: keep bank until standstill
// (RL5) release at standstill returns default bank
// (RL6) per-bank setpoint, used when source is 02
// (RL7) bank without third copy uses default value
// (RL8) brake from input or auto trigger frequency
// (RL9) input code 07 is brake request
// (RL10) auto brake enable 00 off, 01 on
// (RL11) reaching trigger frequency starts delay timer
// (RL12) braking starts only after delay expires
// (RL13) brake request also waits the delay
// (RL14) duration timer starts when delay expires
// (RL15) end mode 00 ends on duration expiry
// (RL16) end mode 01 ends on input release
// (RL17) apply programmed torque while braking
// (RL18) start brake torque and time before accelerating
// (RL19) brake pulse rate, fixed while braking
// (RL20) reduce frequency when current reaches limit
// (RL21) swap input selects second overload group
// (RL22) input code 39 is overload swap
// ------------------------------------------------------------
module dbsdc_top
    import dbsdc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    // clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // avalon-mm slave
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // drive status
    input wire logic [NUM_INPUTS-1:0] DIN_I,
    input wire logic RUN_I,
    input wire logic STOPPED_I,
    input wire logic ACCEL_I,
    input wire logic STEADY_I,
    input wire logic [15:0] OUT_FREQ_I,
    input wire logic [15:0] CURRENT_I,
    // drive control
    output logic [1:0] BANK_SEL_O,
    output logic [15:0] SETPOINT_O,
    output logic [15:0] FREQ_MAX_O,
    output logic DC_BRAKE_O,
    output logic [7:0] BRAKE_TORQUE_O,
    output logic BRAKE_PULSE_O,
    output logic HOLD_ACCEL_O,
    output logic OVL_GROUP_O,
    output logic FREQ_REDUCE_O
);
    dbsdc_regs_t s;
    dbsdc_regs_t n;
    logic req_brake;
    logic sel_bank2;
    logic sel_bank3;
    logic ovl_swap;
    logic allow_ovl;
    logic [1:0] ovl_m;
    logic [17:0] acc_sum;
    logic [31:0] wd;
    logic [3:0] be;

    function automatic logic fn_active(input logic [7:0][7:0] sel, input logic [7:0] din,
                                       input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (din[i] && sel[i] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] en);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (en[b]) begin
                r[8*b+:8] = d[8*b+:8];
            end
        end
        return r;
    endfunction

    function automatic logic timer_done(input logic [15:0] t, input logic [15:0] lim);
        return t >= lim;
    endfunction

    assign wd = AVS_WRITEDATA_I;
    assign be = AVS_BYTEENABLE_I;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        // (RL9) brake request code
        req_brake = fn_active(s.fsel, DIN_I, FN_DC_BRAKE);
        // (RL1) second bank code
        sel_bank2 = fn_active(s.fsel, DIN_I, FN_BANK2);
        // (RL2) third bank code
        sel_bank3 = fn_active(s.fsel, DIN_I, FN_BANK3);
        // (RL22) overload swap code
        ovl_swap = fn_active(s.fsel, DIN_I, FN_OVL_SWAP);
        acc_sum = 18'h00000;
        ovl_m = 2'h0;
        allow_ovl = 1'b0;

        // bus: one wait cycle, then answer for exactly one cycle
        n.waitreq = ~((AVS_READ_I | AVS_WRITE_I) & s.waitreq);
        if (AVS_READ_I && s.waitreq) begin
            if (AVS_ADDRESS_I == OFS_AUTO_EN) begin
                n.rdata = {24'h000000, s.auto_en};
            end else if (AVS_ADDRESS_I == OFS_TRIG_FREQ) begin
                n.rdata = {16'h0000, s.trig_freq};
            end else if (AVS_ADDRESS_I == OFS_DELAY) begin
                n.rdata = {16'h0000, s.delay_t};
            end else if (AVS_ADDRESS_I == OFS_TORQUE) begin
                n.rdata = {24'h000000, s.torque};
            end else if (AVS_ADDRESS_I == OFS_DURATION) begin
                n.rdata = {16'h0000, s.dur_t};
            end else if (AVS_ADDRESS_I == OFS_END_MODE) begin
                n.rdata = {24'h000000, s.end_mode};
            end else if (AVS_ADDRESS_I == OFS_ST_TORQUE) begin
                n.rdata = {24'h000000, s.st_torque};
            end else if (AVS_ADDRESS_I == OFS_ST_TIME) begin
                n.rdata = {16'h0000, s.st_time};
            end else if (AVS_ADDRESS_I == OFS_PULSE_RATE) begin
                n.rdata = {24'h000000, s.pulse_rate};
            end else if (AVS_ADDRESS_I == OFS_FSEL_LO) begin
                n.rdata = s.fsel[3:0];
            end else if (AVS_ADDRESS_I == OFS_FSEL_HI) begin
                n.rdata = s.fsel[7:4];
            end else if (AVS_ADDRESS_I == OFS_SRC_SEL) begin
                n.rdata = {24'h000000, s.src_sel};
            end else if (AVS_ADDRESS_I == OFS_SETPT0) begin
                n.rdata = {16'h0000, s.setpt[0]};
            end else if (AVS_ADDRESS_I == OFS_SETPT1) begin
                n.rdata = {16'h0000, s.setpt[1]};
            end else if (AVS_ADDRESS_I == OFS_SETPT2) begin
                n.rdata = {16'h0000, s.setpt[2]};
            end else if (AVS_ADDRESS_I == OFS_OVL0) begin
                n.rdata = {14'h0000, s.ovl_mode[0], s.ovl_lim[0]};
            end else if (AVS_ADDRESS_I == OFS_OVL1) begin
                n.rdata = {14'h0000, s.ovl_mode[1], s.ovl_lim[1]};
            end else if (AVS_ADDRESS_I == OFS_FMAX0) begin
                n.rdata = {16'h0000, s.fmax[0]};
            end else if (AVS_ADDRESS_I == OFS_FMAX1) begin
                n.rdata = {16'h0000, s.fmax[1]};
            end else if (AVS_ADDRESS_I == OFS_STATUS) begin
                n.rdata = {22'h000000, s.state, s.bank, s.ovl_grp, s.reduce_o, s.hold_o,
                           s.brake_o};
            end else begin
                n.rdata = 32'h00000000;
            end
        end
        // writes land at the edge where waitrequest is seen low
        if (AVS_WRITE_I && !s.waitreq) begin
            if (AVS_ADDRESS_I == OFS_AUTO_EN) begin
                n.auto_en = 8'(be_merge({24'h000000, s.auto_en}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_TRIG_FREQ) begin
                n.trig_freq = 16'(be_merge({16'h0000, s.trig_freq}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_DELAY) begin
                n.delay_t = 16'(be_merge({16'h0000, s.delay_t}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_TORQUE) begin
                n.torque = 8'(be_merge({24'h000000, s.torque}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_DURATION) begin
                n.dur_t = 16'(be_merge({16'h0000, s.dur_t}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_END_MODE) begin
                n.end_mode = 8'(be_merge({24'h000000, s.end_mode}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_ST_TORQUE) begin
                n.st_torque = 8'(be_merge({24'h000000, s.st_torque}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_ST_TIME) begin
                n.st_time = 16'(be_merge({16'h0000, s.st_time}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_PULSE_RATE) begin
                n.pulse_rate = 8'(be_merge({24'h000000, s.pulse_rate}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_FSEL_LO) begin
                n.fsel[3:0] = be_merge(s.fsel[3:0], wd, be);
            end else if (AVS_ADDRESS_I == OFS_FSEL_HI) begin
                n.fsel[7:4] = be_merge(s.fsel[7:4], wd, be);
            end else if (AVS_ADDRESS_I == OFS_SRC_SEL) begin
                n.src_sel = 8'(be_merge({24'h000000, s.src_sel}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_SETPT0) begin
                n.setpt[0] = 16'(be_merge({16'h0000, s.setpt[0]}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_SETPT1) begin
                n.setpt[1] = 16'(be_merge({16'h0000, s.setpt[1]}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_SETPT2) begin
                n.setpt[2] = 16'(be_merge({16'h0000, s.setpt[2]}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_OVL0) begin
                {n.ovl_mode[0], n.ovl_lim[0]} =
                    18'(be_merge({14'h0000, s.ovl_mode[0], s.ovl_lim[0]}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_OVL1) begin
                {n.ovl_mode[1], n.ovl_lim[1]} =
                    18'(be_merge({14'h0000, s.ovl_mode[1], s.ovl_lim[1]}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_FMAX0) begin
                n.fmax[0] = 16'(be_merge({16'h0000, s.fmax[0]}, wd, be));
            end else if (AVS_ADDRESS_I == OFS_FMAX1) begin
                n.fmax[1] = 16'(be_merge({16'h0000, s.fmax[1]}, wd, be));
            end
        end

        // ------------------------------------------------------------
        // parameter banks
        // ------------------------------------------------------------
        // (RL4) bank frozen while the motor turns
        if (STOPPED_I) begin
            // (RL5) no select at standstill means default bank
            n.bank = sel_bank3 ? BANK_3 : (sel_bank2 ? BANK_2 : BANK_DEF);
        end
        // (RL6) setpoint per bank when source is parameter
        n.setpt_o = (s.src_sel == SRC_PARAM) ? s.setpt[s.bank] : 16'h0000;
        // (RL7) no third copy: third bank falls back to default
        n.fmax_o = (s.bank == BANK_3) ? s.fmax[BANK_DEF] : s.fmax[s.bank[0]];

        // ------------------------------------------------------------
        // dc brake sequencer
        // ------------------------------------------------------------
        n.freq_prev = OUT_FREQ_I;
        n.run_prev = RUN_I;
        if (s.state != ST_IDLE) begin
            if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
                n.tick_cnt = '0;
                n.timer = 16'(s.timer + 16'h0001);
            end else begin
                n.tick_cnt = TICK_W'(s.tick_cnt + 1'b1);
            end
        end
        case (s.state)
            ST_IDLE: begin
                n.tick_cnt = '0;
                n.timer = 16'h0000;
                // (RL8) input request has priority over auto trigger
                if (req_brake) begin
                    // (RL13) request goes through the delay too
                    n.state = ST_DELAY;
                    n.by_input = 1'b1;
                // (RL10) auto trigger only when enabled
                end else if (s.auto_en == AUTO_ON && s.freq_prev > s.trig_freq &&
                             OUT_FREQ_I <= s.trig_freq) begin
                    // (RL11) crossing trigger frequency starts delay
                    n.state = ST_DELAY;
                    n.by_input = 1'b0;
                end else if (RUN_I && !s.run_prev && s.st_time != 16'h0000) begin
                    // (RL18) start brake before acceleration
                    n.state = ST_START;
                end
            end
            ST_DELAY: begin
                if (s.by_input && s.end_mode == END_INPUT && !req_brake) begin
                    n.state = ST_IDLE;
                end else if (timer_done(s.timer, s.delay_t)) begin
                    // (RL12) brake only after delay; (RL14) duration starts here
                    n.state = ST_BRAKE;
                    n.timer = 16'h0000;
                    n.tick_cnt = '0;
                end
            end
            ST_BRAKE: begin
                if (s.by_input && s.end_mode == END_INPUT) begin
                    // (RL16) end on input release
                    if (!req_brake) begin
                        n.state = ST_IDLE;
                    end
                end else if (timer_done(s.timer, s.dur_t)) begin
                    // (RL15) end on duration expiry
                    n.state = ST_IDLE;
                end
            end
            ST_START: begin
                if (timer_done(s.timer, s.st_time)) begin
                    n.state = ST_IDLE;
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        n.brake_o = (s.state == ST_BRAKE) || (s.state == ST_START);
        n.hold_o = (s.state == ST_START);
        // (RL17) torque applied while braking
        n.torque_o = (s.state == ST_BRAKE) ? s.torque :
                     ((s.state == ST_START) ? s.st_torque : 8'h00);

        // (RL19) rate is latched at idle so a change cannot disturb a brake cycle
        if (s.state == ST_IDLE) begin
            n.rate_lat = s.pulse_rate;
            n.pulse_acc = 17'h00000;
            n.pulse = 1'b0;
        end else begin
            acc_sum = {1'b0, s.pulse_acc} + {10'h000, s.rate_lat};
            if (acc_sum >= PULSE_WRAP) begin
                n.pulse_acc = 17'(acc_sum - PULSE_WRAP);
                n.pulse = ~s.pulse;
            end else begin
                n.pulse_acc = 17'(acc_sum);
            end
        end

        // ------------------------------------------------------------
        // overload limit
        // ------------------------------------------------------------
        // (RL21) swap input picks the second group
        n.ovl_grp = ovl_swap;
        ovl_m = s.ovl_mode[s.ovl_grp];
        allow_ovl = (ovl_m == OVL_ALWAYS) || (ovl_m == OVL_STEADY && STEADY_I) ||
                    (ovl_m == OVL_ACC_STEADY && (ACCEL_I || STEADY_I));
        // (RL20) reduce frequency at the current limit
        n.reduce_o = allow_ovl && (CURRENT_I >= s.ovl_lim[s.ovl_grp]);

        if (!RST_N_I) begin
            n = '0;
            n.auto_en = RST_AUTO_EN;
            n.trig_freq = RST_TRIG_FREQ;
            n.end_mode = RST_END_MODE;
            n.pulse_rate = RST_PULSE_RATE;
            n.rate_lat = RST_PULSE_RATE;
            n.src_sel = RST_SRC_SEL;
            n.ovl_mode = {RST_OVL_MODE, RST_OVL_MODE};
            n.ovl_lim = {RST_OVL_LIM, RST_OVL_LIM};
            n.fmax = {RST_FMAX, RST_FMAX};
            n.state = ST_IDLE;
            n.waitreq = 1'b1;
        end
    end

    // reset wins over the clock enable so the block always leaves reset clean
    always_ff @(posedge CLK_I) begin
        if (CE_I || !RST_N_I) begin
            s <= n;
        end
    end

    assign AVS_READDATA_O = s.rdata;
    assign AVS_WAITREQUEST_O = s.waitreq;
    assign BANK_SEL_O = s.bank;
    assign SETPOINT_O = s.setpt_o;
    assign FREQ_MAX_O = s.fmax_o;
    assign DC_BRAKE_O = s.brake_o;
    assign BRAKE_TORQUE_O = s.torque_o;
    assign BRAKE_PULSE_O = s.pulse;
    assign HOLD_ACCEL_O = s.hold_o;
    assign OVL_GROUP_O = s.ovl_grp;
    assign FREQ_REDUCE_O = s.reduce_o;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_bus_answer: assert property (CE_I && (AVS_READ_I || AVS_WRITE_I) && s.waitreq
        |=> !s.waitreq ##1 s.waitreq) else $error("bus answer not one cycle");
    a_bank_hold: assert property (CE_I && !STOPPED_I |=> $stable(s.bank)) // (RL4)
        else $error("bank changed while turning");
    a_bank_default: assert property (CE_I && STOPPED_I && !sel_bank2 && !sel_bank3 // (RL5)
        |=> s.bank == BANK_DEF) else $error("bank not default at standstill");
    a_delay_first: assert property (s.state == ST_BRAKE && $past(s.state) == ST_DELAY // (RL12)
        |-> $past(s.timer) >= $past(s.delay_t)) else $error("brake before delay");
    a_auto_off: assert property (CE_I && s.state == ST_IDLE && s.auto_en != AUTO_ON // (RL10)
        && !req_brake |=> s.state != ST_DELAY) else $error("auto brake while disabled");
    a_input_end: assert property (CE_I && s.state == ST_BRAKE && s.by_input // (RL16)
        && s.end_mode == END_INPUT && !req_brake |=> s.state == ST_IDLE)
        else $error("brake held after release");
    a_torque_out: assert property (CE_I && s.state == ST_BRAKE // (RL17)
        |=> s.torque_o == $past(s.torque) && s.brake_o) else $error("wrong brake torque");
    a_rate_fixed: assert property (CE_I && s.state != ST_IDLE && $past(s.state) != ST_IDLE // (RL19)
        |-> $stable(s.rate_lat)) else $error("pulse rate changed while braking");
    a_ovl_group: assert property (CE_I && ovl_swap |=> s.ovl_grp ##0 OVL_GROUP_O) // (RL21)
        else $error("overload group not swapped");
endmodule

// >>> dbsdc_contacts.sv
// control contacts and motor on the far side of the drive
module dbsdc_contacts (
    // bench requests
    input wire logic clk_i,
    input wire logic [7:0] din_req_i,
    input wire logic stop_req_i,
    // levels seen by the drive
    output logic [7:0] din_o,
    output logic stopped_o,
    output logic [15:0] freq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        din_o = 8'h00;
        stopped_o = 1'b1;
        freq_o = 16'h0000;
    end
    always @(posedge clk_i) begin
        din_o <= stopped_o ? din_req_i : din_req_i & (din_o | 8'hFC);
        stopped_o <= stop_req_i;
        freq_o <= stop_req_i ? 16'h0000 : 16'h1770;
    end
endmodule

// >>> dbsdc_top_test.sv
// self-checking bench of the bank select and dc brake block
module dbsdc_top_test import dbsdc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, rd, wr, stop_req, wq, stopped, brk, ovl;
    logic [7:0] adr, din_req, din, trq, trq_o;
    logic [31:0] wd, rdat, xq;
    logic [15:0] freq, setpt, fmx;
    logic [1:0] bank;
    logic [31:0] q[$];
    int n_fail = 0;
    int comparisons = 0;
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // contacts pass one flop in the model, then the block's own pipeline
    task automatic step(input logic [7:0] d, input logic s);
        din_req <= d;
        stop_req <= s;
        repeat (8) @(posedge clk);
    endtask
    dbsdc_contacts far_u (.clk_i(clk), .din_req_i(din_req), .stop_req_i(stop_req),
        .din_o(din), .stopped_o(stopped), .freq_o(freq));
    dbsdc_top #(.TICK_CYCLES(4)) dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
        .DIN_I(din), .RUN_I(1'b0), .STOPPED_I(stopped), .ACCEL_I(1'b0), .STEADY_I(xq[16]),
        .OUT_FREQ_I(freq), .CURRENT_I(xq[15:0]), .BANK_SEL_O(bank), .SETPOINT_O(setpt),
        .FREQ_MAX_O(fmx), .DC_BRAKE_O(brk), .BRAKE_TORQUE_O(trq_o), .BRAKE_PULSE_O(),
        .HOLD_ACCEL_O(), .OVL_GROUP_O(ovl), .FREQ_REDUCE_O());
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        xq <= xs(xq);
        if (rd && wq === 1'b0 && q.size() > 0) chk(rdat, q.pop_front());
    end
    initial begin
        #20us;
        n_fail++;
        end_sim;
    end
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 8'h00;
        wd = 32'h0;
        din_req = 8'h00;
        stop_req = 1'b1;
        xq = 32'd70;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdx(OFS_AUTO_EN, 32'h0);
        rdx(OFS_END_MODE, 32'h1);
        rdx(OFS_PULSE_RATE, 32'h5);
        rdx(8'hF0, 32'h0);
        trq = 8'(xq % 101);
        bus(1'b1, OFS_FSEL_LO, 32'h2707_1108);
        bus(1'b1, OFS_SRC_SEL, 32'h2);
        bus(1'b1, OFS_SETPT1, 32'h1234);
        bus(1'b1, OFS_FMAX1, 32'h0BB8);
        bus(1'b1, OFS_TORQUE, 32'(trq));
        step(8'h01, 1'b1);
        chk(32'(bank), 32'(BANK_2));
        chk(32'(setpt), 32'h1234);
        chk(32'(fmx), 32'h0BB8);
        step(8'h03, 1'b1);
        chk(32'(bank), 32'(BANK_3));
        chk(32'(fmx), 32'(RST_FMAX));
        step(8'h02, 1'b0);
        step(8'h00, 1'b0);
        chk(32'(bank), 32'(BANK_3));
        step(8'h00, 1'b1);
        chk(32'(bank), 32'(BANK_DEF));
        step(8'h04, 1'b1);
        chk(32'(brk), 32'h1);
        chk(32'(trq_o), 32'(trq));
        step(8'h00, 1'b1);
        chk(32'(brk), 32'h0);
        step(8'h08, 1'b1);
        chk(32'(ovl), 32'h1);
        end_sim;
    end
endmodule
